// file: rtl/dual_setpoint_pkg.sv
// Purpose: Shared constants and types for the dual setpoint output timer.
// Assumes: 20 MHz clock; time values held as four BCD-free binary digits 0..9999.
// Notes:   Settings retention is modelled by a small retained store module.
package dual_setpoint_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          TICK_10MS_NS    = 10_000_000;
  localparam int          TICK_10MS_CYC   = TICK_10MS_NS / (1_000_000_000 / CLK_HZ);
  localparam int          POWER_UP_MS     = 200;
  localparam int          POWER_UP_CYC    = POWER_UP_MS * (CLK_HZ / 1000);
  localparam int          STARTUP_MS      = 10;
  localparam int          STARTUP_CYC     = STARTUP_MS * (CLK_HZ / 1000);
  localparam logic [13:0] VALUE_MAX       = 14'h270f;
  localparam logic [13:0] PULSE_MIN       = 14'h0001;
  localparam logic [13:0] SETPOINT_RESET  = 14'h0064;
  localparam logic [13:0] PULSE_RESET     = 14'h0032;
  localparam logic [13:0] EARLY_RESET     = 14'h0000;
  localparam int          RANGE_DIV_10MS  = 1;
  localparam int          RANGE_DIV_100MS = 10;
  localparam int          RANGE_DIV_1S    = 100;
  localparam int          RANGE_DIV_1MIN  = 6000;

  typedef enum logic [2:0] {
    MODE_ON_DELAY, MODE_INTERVAL, MODE_ON_DELAY_TOT, MODE_INTERVAL_TOT,
    MODE_PULSE, MODE_PULSE_REPEAT, MODE_REPEAT_ON_FIRST, MODE_REPEAT_OFF_FIRST
  } out_mode_t;

  typedef enum logic [1:0] {
    RANGE_HUNDREDTH_S, RANGE_TENTH_S, RANGE_MIN_SEC, RANGE_HR_MIN
  } time_range_t;

  typedef struct packed {
    out_mode_t   mode;
    time_range_t range;
    logic        both_outputs;   // Mode drives both outputs
    logic        out2_prewarn;   // Output two is early trip, else parallel
    logic        count_up;       // Display counts up from zero
  } timer_cfg_t;

  typedef struct packed {
    logic [13:0] setpoint;
    logic [13:0] early_trip;
    logic [13:0] pulse_len;
  } timer_set_t;

  localparam int SET_W = $bits(timer_set_t);
endpackage : dual_setpoint_pkg

// file: rtl/retained_settings_store.sv
// Purpose: Retained store for setpoints and accumulated time.
// Assumes: Storage cells are not cleared by reset, as nonvolatile cells keep data.
// Notes:   Writes are gated by the caller; reads are always current.
`timescale 1ns/1ps
`default_nettype none
module retained_settings_store (
  input  wire logic                          clk_in,
  input  wire logic                          ce_in,
  input  wire logic                          wr_set_in,
  input  wire dual_setpoint_pkg::timer_set_t set_in,
  input  wire logic                          wr_acc_in,
  input  wire logic [13:0]                   acc_in,
  output logic                               valid_out,
  output dual_setpoint_pkg::timer_set_t      set_out,
  output logic [13:0]                        acc_out
);
  import dual_setpoint_pkg::*;
  // Two cells: settings and accumulated time, no reset so they survive it
  logic [SET_W-1:0] store_mem [0:0];
  logic [13:0]      acc_mem   [0:0];
  logic             written_q = 1'b0;
  logic             acc_written_q = 1'b0;

  // Store writes; settings survive reset as a retained array would
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_set_in) begin
      store_mem[0] <= set_in;
      written_q    <= 1'b1;
    end
    // Settings may be written before any time has run; track the time cell alone
    if (ce_in && wr_acc_in) begin
      acc_mem[0]    <= acc_in;
      acc_written_q <= 1'b1;
    end
  end

  assign valid_out = written_q;
  assign set_out   = written_q ? timer_set_t'(store_mem[0])
                               : timer_set_t'({SETPOINT_RESET, EARLY_RESET, PULSE_RESET});
  assign acc_out   = acc_written_q ? acc_mem[0] : 14'h0000;
endmodule : retained_settings_store
`default_nettype wire

// file: rtl/dual_setpoint_output_timer.sv
// Purpose: Dual setpoint timer driving two relay outputs in eight modes.
// Assumes: Field inputs are asynchronous and synchronised here; keypad is on clk_in.
// Notes:   Time advances in range ticks; pulse length always counts 10 ms ticks.
`timescale 1ns/1ps
`default_nettype none
module dual_setpoint_output_timer #(
  parameter int POWER_UP_CYCLES = dual_setpoint_pkg::STARTUP_CYC,
  parameter int BASE_TICK_CYCLES = dual_setpoint_pkg::TICK_10MS_CYC
) (
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  input  wire logic                          ce_in,
  input  wire dual_setpoint_pkg::timer_cfg_t cfg_in,
  input  wire logic                          inhibit_in,
  input  wire logic                          remote_reset_in,
  input  wire logic                          panel_reset_in,
  input  wire logic                          key_lock_in,
  input  wire logic                          key_wr_in,
  input  wire dual_setpoint_pkg::timer_set_t key_set_in,
  output logic                               out1_out,
  output logic                               out2_out,
  output logic [13:0]                        display_out,
  output dual_setpoint_pkg::timer_set_t      set_view_out,
  output logic                               ready_out,
  output logic                               timing_out
);
  import dual_setpoint_pkg::*;

  typedef enum logic [1:0] {ST_START, ST_TIMING, ST_PULSE, ST_DONE} run_state_t;

  // Two-flop synchronisers for field pins
  logic [1:0] inh_sync_q, rrst_sync_q;
  logic       rrst_prev_q;
  run_state_t state_q, state_d;
  logic [13:0] elapsed_q, elapsed_d;
  logic [13:0] pulse_q, pulse_d;
  logic        phase_q, phase_d;
  logic [22:0] base_cnt_q;
  logic [12:0] range_cnt_q;
  logic [22:0] pwr_cnt_q;
  logic        ready_q;
  logic        out1_q, out1_d, out2_q, out2_d;
  logic [13:0] disp_q;
  timer_set_t  set_view_q;
  logic        restored_q;
  logic        timing_q;
  timer_set_t  cur_set;
  logic [13:0] acc_stored;
  logic        store_valid;

  // Range divisor lookup, used for the period ticker
  function automatic logic [12:0] range_div(input time_range_t r);
    if (r == RANGE_HUNDREDTH_S)  return 13'(RANGE_DIV_10MS);
    else if (r == RANGE_TENTH_S) return 13'(RANGE_DIV_100MS);
    else if (r == RANGE_MIN_SEC) return 13'(RANGE_DIV_1S);
    else                         return 13'(RANGE_DIV_1MIN);
  endfunction : range_div

  wire inhibit    = inh_sync_q[1];
  wire rrst_edge  = rrst_sync_q[1] & ~rrst_prev_q;
  wire any_reset  = panel_reset_in | rrst_edge;
  wire run        = ce_in & ready_q & ~inhibit;
  wire base_tick  = run && (base_cnt_q == 23'(BASE_TICK_CYCLES - 1));
  wire range_tick = base_tick && (range_cnt_q == range_div(cfg_in.range) - 13'h0001);
  wire at_end     = (elapsed_q >= cur_set.setpoint);
  wire [13:0] remaining = at_end ? 14'h0000 : cur_set.setpoint - elapsed_q;
  wire totalize   = (cfg_in.mode == MODE_ON_DELAY_TOT) || (cfg_in.mode == MODE_INTERVAL_TOT);
  wire repeat_md  = (cfg_in.mode == MODE_REPEAT_ON_FIRST) || (cfg_in.mode == MODE_REPEAT_OFF_FIRST);
  wire key_write  = key_wr_in & ~key_lock_in & ready_q;
  // Registers may advance this cycle: enabled, ready, restored, not held or reset
  wire upd        = ce_in & ready_q & restored_q & ~inhibit & ~any_reset;
  wire [13:0] left_d = cur_set.setpoint - elapsed_d; // Wraps past setpoint, so gated

  // Settings and accumulated time live in the retained store
  retained_settings_store store_u (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .wr_set_in (key_write),
    .set_in    (key_set_in),
    .wr_acc_in (range_tick),
    .acc_in    (elapsed_d),
    .valid_out (store_valid),
    .set_out   (cur_set),
    .acc_out   (acc_stored)
  );

  // Field input synchronisers; first flop feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      inh_sync_q  <= 2'b00;
      rrst_sync_q <= 2'b00;
      rrst_prev_q <= 1'b0;
    end else if (ce_in) begin
      inh_sync_q  <= {inh_sync_q[0], inhibit_in};
      rrst_sync_q <= {rrst_sync_q[0], remote_reset_in};
      rrst_prev_q <= rrst_sync_q[1];
    end
  end

  // Power-up delay; startup stays well inside the response limit
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_cnt_q <= 23'h000000;
      ready_q   <= 1'b0;
    end else if (ce_in && !ready_q) begin
      pwr_cnt_q <= pwr_cnt_q + 23'h000001;
      ready_q   <= (pwr_cnt_q == 23'(POWER_UP_CYCLES - 1));
    end
  end

  // Base 10 ms ticker and range prescaler, both held while inhibited
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_cnt_q  <= 23'h000000;
      range_cnt_q <= 13'h0000;
    end else if (ce_in && any_reset) begin
      base_cnt_q  <= 23'h000000;
      range_cnt_q <= 13'h0000;
    end else if (run) begin
      base_cnt_q <= base_tick ? 23'h000000 : base_cnt_q + 23'h000001;
      if (range_tick)     range_cnt_q <= 13'h0000;
      else if (base_tick) range_cnt_q <= range_cnt_q + 13'h0001;
    end
  end

  // Cycle sequencing: timing, pulse, done, with repeat restarts
  always_comb begin
    state_d   = state_q;
    elapsed_d = elapsed_q;
    pulse_d   = pulse_q;
    phase_d   = phase_q;
    if (state_q == ST_START) begin
      state_d   = ST_TIMING;
      elapsed_d = 14'h0000;
      phase_d   = (cfg_in.mode == MODE_REPEAT_ON_FIRST);
    end else if (range_tick && (state_q == ST_TIMING || (state_q == ST_DONE && totalize))) begin
      elapsed_d = (elapsed_q == VALUE_MAX) ? VALUE_MAX : elapsed_q + 14'h0001;
    end
    case (state_q)
      ST_TIMING: begin
        if (elapsed_d >= cur_set.setpoint) begin
          if (cfg_in.mode == MODE_PULSE || cfg_in.mode == MODE_PULSE_REPEAT) begin
            state_d = ST_PULSE;
            pulse_d = (cur_set.pulse_len < PULSE_MIN) ? PULSE_MIN :
                      (cur_set.pulse_len > VALUE_MAX) ? VALUE_MAX : cur_set.pulse_len;
          end else if (repeat_md) begin
            elapsed_d = 14'h0000;
            phase_d   = ~phase_q;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_PULSE: begin
        if (base_tick) begin
          pulse_d = pulse_q - 14'h0001;
          if (pulse_q == 14'h0001) begin
            if (cfg_in.mode == MODE_PULSE_REPEAT) begin
              state_d   = ST_TIMING;
              elapsed_d = 14'h0000;
            end else begin
              state_d = ST_DONE;
            end
          end
        end
      end
      default: ;
    endcase
  end

  // Output one from mode and state
  always_comb begin
    out1_d = 1'b0;
    case (cfg_in.mode)
      MODE_ON_DELAY, MODE_ON_DELAY_TOT: out1_d = (state_d == ST_DONE);
      MODE_INTERVAL, MODE_INTERVAL_TOT: out1_d = (state_d == ST_TIMING);
      MODE_PULSE, MODE_PULSE_REPEAT:    out1_d = (state_d == ST_PULSE);
      default:                          out1_d = phase_d;
    endcase
    // Prewarn compares remaining time with the early-trip setpoint while timing
    if (cfg_in.both_outputs && !cfg_in.out2_prewarn)
      out2_d = out1_d;
    else if (cfg_in.both_outputs)
      out2_d = (state_d == ST_TIMING) && (left_d <= cur_set.early_trip)
               && (elapsed_d < cur_set.setpoint);
    else
      out2_d = 1'b0;
  end

  // Main state registers; inhibit holds them, reset clears value and outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q   <= ST_START;
      elapsed_q <= 14'h0000;
      pulse_q   <= 14'h0000;
      phase_q   <= 1'b0;
      out1_q    <= 1'b0;
      out2_q    <= 1'b0;
      restored_q <= 1'b0;
    end else if (ce_in && ready_q) begin
      if (any_reset) begin
        state_q   <= ST_START;
        elapsed_q <= 14'h0000;
        pulse_q   <= 14'h0000;
        phase_q   <= 1'b0;
        out1_q    <= 1'b0;
        out2_q    <= 1'b0;
        restored_q <= 1'b1;
      end else if (!restored_q) begin
        restored_q <= 1'b1;
        state_q    <= ST_TIMING;
        elapsed_q  <= store_valid ? acc_stored : 14'h0000;
        phase_q    <= (cfg_in.mode == MODE_REPEAT_ON_FIRST);
      end else if (!inhibit) begin
        state_q   <= state_d;
        elapsed_q <= elapsed_d;
        pulse_q   <= pulse_d;
        phase_q   <= phase_d;
        out1_q    <= out1_d;
        out2_q    <= out2_d;
      end
    end
  end

  // Display direction and setpoint view (view works even when locked)
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      disp_q     <= 14'h0000;
      set_view_q <= '0;
      timing_q   <= 1'b0;
    end else if (ce_in) begin
      disp_q     <= (cfg_in.count_up || totalize) ? elapsed_q : remaining;
      set_view_q <= cur_set;
      timing_q   <= (state_q == ST_TIMING) & ~inhibit & ready_q;
    end
  end

  assign out1_out     = out1_q;
  assign out2_out     = out2_q;
  assign display_out  = disp_q;
  assign set_view_out = set_view_q;
  assign ready_out    = ready_q;
  assign timing_out   = timing_q;

  // Inhibit keeps output one and the value
  inhibit_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && inhibit && !any_reset && restored_q) |=>
    ($stable(out1_q) && $stable(elapsed_q))) else $error("inhibit changed state");
  // Reset clears value and outputs
  reset_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && ready_q && any_reset) |=> (!out1_q && !out2_q && elapsed_q == 14'h0000))
    else $error("reset did not clear");
  // Parallel output two follows output one
  parallel_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.both_outputs && !cfg_in.out2_prewarn && $stable(cfg_in)) |=>
    (out2_q == out1_q || $past(any_reset) || $past(inhibit)))
    else $error("output two not parallel");
  // On-delay output off while timing
  on_delay_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.mode == MODE_ON_DELAY && $past(cfg_in.mode) == MODE_ON_DELAY
     && state_q == ST_TIMING && $past(state_q) == ST_TIMING)
    |-> !out1_q) else $error("on delay output early");
  // Interval output on while timing
  interval_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.mode == MODE_INTERVAL && ce_in && ready_q && !inhibit && !any_reset
     && restored_q && state_d == ST_TIMING) |=> out1_q) else $error("interval output off");
  // Pulse length never below one count
  pulse_len_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == ST_PULSE) |-> (pulse_q != 14'h0000)) else $error("zero pulse");
  // Locked keypad cannot write
  key_lock_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    key_lock_in |-> !key_write) else $error("locked write");
  // Ready within power-up limit
  power_up_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && pwr_cnt_q == 23'(POWER_UP_CYCLES)) |-> ready_q) else $error("slow start");
  // Reset pulse restarts cycle
  restart_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && ready_q && panel_reset_in) |=> (state_q == ST_START))
    else $error("reset no restart");
  // Pulse-and-repeat goes back to timing from zero on its own
  pulse_repeat_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && state_q == ST_PULSE && cfg_in.mode == MODE_PULSE_REPEAT && base_tick
     && pulse_q == 14'h0001) |=> (state_q == ST_TIMING && elapsed_q == 14'h0000))
    else $error("pulse did not repeat");
  // Single pulse ends and drops output one
  pulse_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && state_q == ST_PULSE && cfg_in.mode == MODE_PULSE && base_tick
     && pulse_q == 14'h0001) |=> (state_q == ST_DONE && !out1_q))
    else $error("pulse did not end");
  // On-delay output energises at cycle end
  on_delay_done_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && cfg_in.mode == MODE_ON_DELAY && state_d == ST_DONE)
    |=> out1_q)
    else $error("on delay output missing");
  // Output two stays off when the mode governs output one only
  out2_single_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && !cfg_in.both_outputs)
    |=> !out2_q)
    else $error("output two driven alone");
  // Prewarn switches on when remaining time meets early trip
  prewarn_on_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && cfg_in.both_outputs && cfg_in.out2_prewarn && state_d == ST_TIMING
     && elapsed_d < cur_set.setpoint && left_d == cur_set.early_trip) |=> out2_q)
    else $error("prewarn missing");
  // Totalizing keeps counting past the setpoint
  total_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && totalize && state_q == ST_DONE && range_tick && elapsed_q != VALUE_MAX)
    |=> (elapsed_q == $past(elapsed_q) + 14'h0001))
    else $error("total stopped");
  // Repeat cycle flips output one and restarts from zero
  repeat_flip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && repeat_md && state_q == ST_TIMING && phase_d != phase_q)
    |=> (elapsed_q == 14'h0000 && out1_q != $past(phase_q)))
    else $error("repeat did not flip");
  // Remote edge restarts the cycle and drops output one
  remote_edge_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && ready_q && rrst_edge)
    |=> (state_q == ST_START && !out1_q))
    else $error("remote reset ignored");
  // Counting up shows elapsed time
  display_up_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && cfg_in.count_up)
    |=> (display_out == $past(elapsed_q)))
    else $error("display not elapsed");
  // Accepted keypad write reaches the view two cycles on
  view_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && key_write) ##1 ce_in
    |=> (set_view_out == $past(key_set_in, 2)))
    else $error("setting not stored");
  // Loaded pulse length stays inside its range
  pulse_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (upd && state_q == ST_TIMING && state_d == ST_PULSE)
    |=> (pulse_q >= PULSE_MIN && pulse_q <= VALUE_MAX))
    else $error("pulse length range");
  // Inhibit holds output two as well
  inhibit_out2_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ce_in && inhibit && !any_reset && restored_q)
    |=> $stable(out2_q))
    else $error("inhibit moved output two");
  // Once ready the device stays ready until a hard reset
  ready_stay_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ready_q
    |=> ready_q)
    else $error("ready dropped");
endmodule : dual_setpoint_output_timer
`default_nettype wire

// file: verification/field_side_model.sv
// Purpose: Field side of the timer: remote reset contact and inhibit switch.
// Assumes: Requests arrive from the bench on clk_in.
// Notes:   A remote closure is held 4 cycles, as a real contact would be.
`timescale 1ns/1ps
`default_nettype none
module field_side_model (
  input  wire logic clk_in,
  input  wire logic remote_req_in,
  input  wire logic inhibit_req_in,
  output logic      remote_reset_out,
  output logic      inhibit_out
);
  logic [2:0] hold_q = 3'h0;

  // Stretch a one-cycle request into a contact closure
  always_ff @(posedge clk_in) begin
    hold_q <= remote_req_in ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
  end
  assign remote_reset_out = (hold_q != 3'h0);
  assign inhibit_out      = inhibit_req_in;
endmodule : field_side_model
`default_nettype wire

// file: verification/dual_setpoint_output_timer_bench.sv
// Purpose: Self-checking bench for the dual setpoint output timer.
// Assumes: Short power-up and tick parameters; setpoint 10 ticks of 2 cycles.
// Notes:   Reset and lock first, then mode rows, direction, range, field, prewarn and retention tests.
`timescale 1ns/1ps
`default_nettype none
module dual_setpoint_output_timer_bench;
  import dual_setpoint_pkg::*;
  localparam int BT      = 2;
  localparam int DIVS[4] = '{RANGE_DIV_10MS, RANGE_DIV_100MS, RANGE_DIV_1S, RANGE_DIV_1MIN};
  typedef struct {out_mode_t mode; logic both, mid, rose, fell; int hilen;} row_t;
  row_t rows[9] = '{
    '{MODE_ON_DELAY, 1'b1, 1'b0, 1'b1, 1'b0, 0},
    '{MODE_INTERVAL, 1'b1, 1'b1, 1'b0, 1'b1, 0},
    '{MODE_ON_DELAY_TOT, 1'b1, 1'b0, 1'b1, 1'b0, 0},
    '{MODE_INTERVAL_TOT, 1'b1, 1'b1, 1'b0, 1'b1, 0},
    '{MODE_PULSE, 1'b1, 1'b0, 1'b1, 1'b1, 4 * BT},
    '{MODE_PULSE_REPEAT, 1'b1, 1'b0, 1'b1, 1'b1, 4 * BT},
    '{MODE_REPEAT_ON_FIRST, 1'b1, 1'b1, 1'b1, 1'b1, 10 * BT},
    '{MODE_REPEAT_OFF_FIRST, 1'b1, 1'b0, 1'b1, 1'b1, 10 * BT},
    '{MODE_ON_DELAY, 1'b0, 1'b0, 1'b1, 1'b0, 0}};
  logic        clk_in = 1'b0, nrst_in = 1'b0, panel_reset_in = 1'b0;
  logic        key_lock_in = 1'b0, key_wr_in = 1'b0, remote_req = 1'b0, inhibit_req = 1'b0;
  logic        remote_w, inhibit_w, out1_out, out2_out, ready_out, timing_out;
  logic        rose, fell, done, par, prev;
  logic [13:0] display_out, held;
  timer_cfg_t  cfg_in = '0;
  timer_set_t  key_set_in = '0, set_view_out, set_a;
  int          mismatches = 0, comparisons = 0, len, t1, t2;

  always #25 clk_in = ~clk_in;

  dual_setpoint_output_timer #(.POWER_UP_CYCLES(4), .BASE_TICK_CYCLES(BT)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .cfg_in(cfg_in),
    .inhibit_in(inhibit_w), .remote_reset_in(remote_w), .panel_reset_in(panel_reset_in),
    .key_lock_in(key_lock_in), .key_wr_in(key_wr_in), .key_set_in(key_set_in),
    .out1_out(out1_out), .out2_out(out2_out), .display_out(display_out),
    .set_view_out(set_view_out), .ready_out(ready_out), .timing_out(timing_out));

  field_side_model field (
    .clk_in(clk_in), .remote_req_in(remote_req), .inhibit_req_in(inhibit_req),
    .remote_reset_out(remote_w), .inhibit_out(inhibit_w));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic pick(input int sel);
    return (sel == 0) ? out1_out : (sel == 1) ? out2_out : ready_out;
  endfunction : pick

  // Bounded wait on an output; running out counts as a mismatch
  task automatic wait_for(input int sel, input logic val, input int bound);
    int n;
    n = 0;
    while (pick(sel) !== val) begin
      @(negedge clk_in);
      n++;
      if (n > bound) begin
        check("wait_bound", 42'(sel), 42'(val) + 42'h100);
        final_report();
      end
    end
  endtask : wait_for

  task automatic restart(input timer_cfg_t c);
    @(posedge clk_in);
    cfg_in <= c;
    @(posedge clk_in);
    panel_reset_in <= 1'b1;
    @(posedge clk_in);
    panel_reset_in <= 1'b0;
    @(negedge clk_in);
  endtask : restart

  task automatic key_write(input timer_set_t s);
    @(posedge clk_in);
    key_set_in <= s;
    key_wr_in  <= 1'b1;
    @(posedge clk_in);
    key_wr_in  <= 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : key_write

  initial begin
    set_a = '{14'h000a, 14'h0003, 14'h0004};
    repeat (20) @(negedge clk_in);
    check("out1_in_reset", out1_out, 1'b0);
    check("out2_in_reset", out2_out, 1'b0);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_for(2, 1'b1, 8);
    key_write(set_a);
    check("view_written", set_view_out, set_a);
    key_lock_in <= 1'b1;
    key_write('{14'h0014, 14'h0005, 14'h0006});
    check("view_locked", set_view_out, set_a);
    key_lock_in <= 1'b0;
    // Mode table: mid-cycle level, edges, output two and high time
    for (int i = 0; i < 9; i++) begin
      restart('{rows[i].mode, RANGE_HUNDREDTH_S, rows[i].both, 1'b0, 1'b1});
      repeat (10) @(negedge clk_in);
      check("out1_mid", out1_out, rows[i].mid);
      check("timing_mid", timing_out, 1'b1);
      {rose, fell, done, par, len, prev} = {4'b0001, 32'd0, out1_out};
      repeat (70) begin
        @(negedge clk_in);
        if (out2_out !== (rows[i].both & out1_out)) par = 1'b0;
        if (out1_out === 1'b1 && prev === 1'b0) rose = 1'b1;
        if (out1_out === 1'b0 && prev === 1'b1) begin
          fell = 1'b1;
          if (rose) done = 1'b1;
        end
        if (rose && !done && out1_out === 1'b1) len++;
        prev = out1_out;
      end
      check("out1_rose", rose, rows[i].rose);
      check("out1_fell", fell, rows[i].fell);
      check("out2_follow", par, 1'b1);
      if (rows[i].hilen != 0) check("out1_high_len", 42'(len), 42'(rows[i].hilen));
    end
    // Direction of the display and totalizing past the setpoint
    restart('{MODE_ON_DELAY, RANGE_HUNDREDTH_S, 1'b1, 1'b0, 1'b0});
    repeat (40) @(negedge clk_in);
    check("disp_down_end", display_out, 14'h0000);
    restart('{MODE_ON_DELAY, RANGE_HUNDREDTH_S, 1'b1, 1'b0, 1'b1});
    repeat (40) @(negedge clk_in);
    check("disp_up_end", display_out, 14'h000a);
    restart('{MODE_ON_DELAY_TOT, RANGE_HUNDREDTH_S, 1'b1, 1'b0, 1'b1});
    repeat (40) @(negedge clk_in);
    check("disp_total", display_out > 14'h000a, 1'b1);
    // Tick length of each range, measured between two display steps
    for (int r = 0; r < 4; r++) begin
      restart('{MODE_ON_DELAY_TOT, time_range_t'(r), 1'b1, 1'b0, 1'b1});
      repeat (3) @(negedge clk_in);
      for (int k = 0; k < 2; k++) begin
        held = display_out;
        len  = 0;
        while (display_out === held && len < 13000) begin
          @(negedge clk_in);
          len++;
        end
      end
      check("range_tick", 42'(len), 42'(BT * DIVS[r]));
    end
    // Inhibit freezes the count, then holds an energised output
    restart('{MODE_ON_DELAY, RANGE_HUNDREDTH_S, 1'b1, 1'b0, 1'b1});
    repeat (8) @(negedge clk_in);
    @(posedge clk_in);
    inhibit_req <= 1'b1;
    repeat (5) @(negedge clk_in);
    held = display_out;
    repeat (40) @(negedge clk_in);
    check("inh_disp", display_out, held);
    check("inh_out1_off", out1_out, 1'b0);
    @(posedge clk_in);
    inhibit_req <= 1'b0;
    wait_for(0, 1'b1, 40);
    @(posedge clk_in);
    inhibit_req <= 1'b1;
    repeat (20) @(negedge clk_in);
    check("inh_out1_on", out1_out, 1'b1);
    @(posedge clk_in);
    inhibit_req <= 1'b0;
    // Remote reset through the field contact
    @(posedge clk_in);
    remote_req <= 1'b1;
    @(posedge clk_in);
    remote_req <= 1'b0;
    wait_for(0, 1'b0, 10);
    @(negedge clk_in);
    check("remote_disp", display_out <= 14'h0001, 1'b1);
    // Prewarn leads the cycle end by the early-trip setpoint
    restart('{MODE_ON_DELAY, RANGE_HUNDREDTH_S, 1'b1, 1'b1, 1'b1});
    {t1, t2} = 64'd0;
    for (int c = 1; c <= 60; c++) begin
      @(negedge clk_in);
      if (t2 == 0 && out2_out === 1'b1) t2 = c;
      if (t1 == 0 && out1_out === 1'b1) t1 = c;
    end
    check("prewarn_lead", 42'(t1 - t2), 42'(3 * BT));
    // Settings survive a reset in mid-run
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_for(2, 1'b1, 8);
    repeat (3) @(negedge clk_in);
    check("view_retained", set_view_out, set_a);
    final_report();
  end
endmodule : dual_setpoint_output_timer_bench
`default_nettype wire
